// ---- rtl/host_bus_config_mac_regs.sv ----
// Purpose: Bus error status, chip configuration and station address registers
// Assumes: Host access is a one-cycle rd/wr strobe on ref_clk; prom reader answers words
// Notes:   Straps are synchronised and taken once, right after reset release
//
// How it works
// - Illegal lane combination sets flag bit 15; host clears it by writing one.
// - Offending lane pattern stored in bits 14..11, lane 3 highest.
// - Pattern field is meaningful only while the flag is set.
// - Serial clock strap latched into config bit 10 at reset: endian select.
// - Prom enable strap latched into config bit 9 at reset: prom fitted.
// - Config bit 7, 8-bit bus, from prom or serial data strap.
// - Config bit 6, 16-bit bus, from prom or serial data strap.
// - Config bit 5 is one on the 32-bit bus variant.
// - Config bit 3 is one in the large package; read-only.
// - With prom fitted, station address loads from prom words from 0x1.
// - Word 1 to low, word 2 to middle, word 3 to high register.
// - Station address registers are 16-bit read/write, low word least significant.
// - Host writes change register copies only, never the prom.
`timescale 1ns/1ps

module host_bus_config_mac_regs
  import host_regs_pkg::*;
#(
  parameter bit BUS32_VARIANT  = 1'b0,
  parameter bit LARGE_PACKAGE  = 1'b1
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Strap pins
  input  wire logic        serial_clock_strap,
  input  wire logic        prom_enable_strap,
  input  wire logic        serial_data_in_strap,
  // Host access
  input  wire host_req_t   host_req,
  output logic [15:0]      host_rdata,
  output logic             host_rvalid,
  // Prom word reader
  output logic             prom_req,
  output logic [7:0]       prom_word,
  input  wire logic        prom_ack,
  input  wire logic [15:0] prom_data,
  // Status
  output logic             load_done
);

  // Whole block state, registered as one word
  regs_state_t state_reg;
  regs_state_t state_next;

  // Legal lane sets: single byte, aligned halfword, full word
  function automatic logic lanes_legal(input logic [3:0] en);
    case (en)
      4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF: lanes_legal = 1'b1;
      default:                                    lanes_legal = 1'b0;
    endcase
  endfunction

  // Word match; address bit 0 only picks a byte lane
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:1] == off[7:1]);
  endfunction

  // Read views of the two status words
  logic [15:0] bus_error_status_view;
  logic [15:0] ccr_view;
  logic        acc;

  always_comb begin
    state_next = state_reg;
    acc        = host_req.rd | host_req.wr;

    // Strap synchronisers
    state_next.sync1_endian = serial_clock_strap;
    state_next.sync2_endian = state_reg.sync1_endian;
    state_next.sync1_prom   = prom_enable_strap;
    state_next.sync2_prom   = state_reg.sync1_prom;
    state_next.sync1_sdi    = serial_data_in_strap;
    state_next.sync2_sdi    = state_reg.sync1_sdi;

    // Reserved bits read zero and writes to them are dropped
    bus_error_status_view = RST_WORD;
    bus_error_status_view[LANE_FLAG_BIT] = state_reg.lane_flag;
    // Pattern shown only with flag set
    bus_error_status_view[LANE_PAT_LSB +: 4] = state_reg.lane_flag ? state_reg.lane_pattern : RST_PATTERN;

    ccr_view = RST_WORD;
    ccr_view[CFG_ENDIAN_BIT] = state_reg.cfg_endian;
    ccr_view[CFG_PROM_BIT]   = state_reg.cfg_prom;
    ccr_view[CFG_BUS8_BIT]   = state_reg.cfg_bus8;
    ccr_view[CFG_BUS16_BIT]  = state_reg.cfg_bus16;
    ccr_view[CFG_BUS32_BIT]  = BUS32_VARIANT;
    ccr_view[CFG_PKG128_BIT] = LARGE_PACKAGE;

    // Strap capture one time after reset, once synchronised
    if (!state_reg.straps_taken && state_reg.ld_state == LD_IDLE) begin
      state_next.straps_taken = 1'b1;
      state_next.cfg_endian   = state_reg.sync2_endian;
      state_next.cfg_prom     = state_reg.sync2_prom;
      state_next.cfg_bus8     = state_reg.sync2_sdi;
      state_next.cfg_bus16    = state_reg.sync2_sdi;
      state_next.ld_state     = state_reg.sync2_prom ? LD_CFG : LD_DONE;
      state_next.prom_req     = state_reg.sync2_prom;
      state_next.prom_word    = PROM_WORD_CONFIG;
    end

    // Prom load sequence; prom is only read, never written
    case (state_reg.ld_state)
      LD_IDLE: begin
        // Waiting for the strap capture above
      end
      LD_CFG: begin
        if (prom_ack) begin
          state_next.cfg_bus8  = prom_data[1];
          state_next.cfg_bus16 = prom_data[0];
          state_next.prom_word = PROM_WORD_ADDR_LOW;
          state_next.ld_state  = LD_LOW;
        end
      end
      LD_LOW: begin
        if (prom_ack) begin
          state_next.addr_low  = prom_data;
          state_next.prom_word = PROM_WORD_ADDR_MID;
          state_next.ld_state  = LD_MID;
        end
      end
      LD_MID: begin
        if (prom_ack) begin
          state_next.addr_mid  = prom_data;
          state_next.prom_word = PROM_WORD_ADDR_HIGH;
          state_next.ld_state  = LD_HIGH;
        end
      end
      LD_HIGH: begin
        if (prom_ack) begin
          state_next.addr_high = prom_data;
          state_next.prom_req  = 1'b0;
          state_next.ld_state  = LD_DONE;
        end
      end
      LD_DONE: begin
        // Held until the next reset
        state_next.load_done = 1'b1;
      end
      default: begin
        state_next.ld_state = LD_DONE;
      end
    endcase

    // Host writes
    state_next.rvalid = 1'b0;
    // Configuration word takes no writes
    if (host_req.wr) begin
      if (hit(host_req.addr, OFF_BUS_ERROR_STATUS) && host_req.wdata[LANE_FLAG_BIT]) begin
        state_next.lane_flag = 1'b0;
      end
      // Copies only; prom untouched
      if (hit(host_req.addr, OFF_STATION_ADDR_LOW)) begin
        state_next.addr_low = host_req.wdata;
      end
      if (hit(host_req.addr, OFF_STATION_ADDR_MID)) begin
        state_next.addr_mid = host_req.wdata;
      end
      if (hit(host_req.addr, OFF_STATION_ADDR_HIGH)) begin
        state_next.addr_high = host_req.wdata;
      end
    end

    // Illegal lanes: set wins over clear; pattern frozen while flagged
    if (acc && !lanes_legal(host_req.lane_en)) begin
      state_next.lane_flag = 1'b1;
      if (!state_reg.lane_flag) begin
        state_next.lane_pattern = host_req.lane_en;
      end
    end

    // Host reads, answered one cycle later
    if (host_req.rd) begin
      state_next.rvalid = 1'b1;
      if (hit(host_req.addr, OFF_BUS_ERROR_STATUS)) begin
        state_next.rdata = bus_error_status_view;
      end else if (hit(host_req.addr, OFF_CHIP_CONFIGURATION)) begin
        state_next.rdata = ccr_view;
      end else if (hit(host_req.addr, OFF_STATION_ADDR_LOW)) begin
        state_next.rdata = state_reg.addr_low;
      end else if (hit(host_req.addr, OFF_STATION_ADDR_MID)) begin
        state_next.rdata = state_reg.addr_mid;
      end else if (hit(host_req.addr, OFF_STATION_ADDR_HIGH)) begin
        state_next.rdata = state_reg.addr_high;
      end else begin
        state_next.rdata = RST_WORD;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg              <= '0;
      state_reg.ld_state     <= LD_IDLE;
      // Synchronisers keep running so straps are settled at release
      state_reg.sync1_endian <= serial_clock_strap;
      state_reg.sync2_endian <= state_reg.sync1_endian;
      state_reg.sync1_prom   <= prom_enable_strap;
      state_reg.sync2_prom   <= state_reg.sync1_prom;
      state_reg.sync1_sdi    <= serial_data_in_strap;
      state_reg.sync2_sdi    <= state_reg.sync1_sdi;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign host_rdata  = state_reg.rdata;
  assign host_rvalid = state_reg.rvalid;
  assign prom_req    = state_reg.prom_req;
  assign prom_word   = state_reg.prom_word;
  assign load_done   = state_reg.load_done;

endmodule

// ---- rtl/host_regs_pkg.sv ----
// Purpose: Shared constants and carriers for the host config/address register group
// Assumes: 16-bit register words addressed by byte offset
// Notes:   Offsets are byte addresses of the low byte of each word
package host_regs_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // Register offsets
  localparam logic [7:0] OFF_BUS_ERROR_STATUS   = 8'h06;
  localparam logic [7:0] OFF_CHIP_CONFIGURATION = 8'h08;
  localparam logic [7:0] OFF_STATION_ADDR_LOW   = 8'h10;
  localparam logic [7:0] OFF_STATION_ADDR_MID   = 8'h12;
  localparam logic [7:0] OFF_STATION_ADDR_HIGH  = 8'h14;

  // Bus error status fields
  localparam int unsigned LANE_FLAG_BIT = 15;
  localparam int unsigned LANE_PAT_LSB  = 11;

  // Chip configuration fields
  localparam int unsigned CFG_ENDIAN_BIT = 10;
  localparam int unsigned CFG_PROM_BIT   = 9;
  localparam int unsigned CFG_BUS8_BIT   = 7;
  localparam int unsigned CFG_BUS16_BIT  = 6;
  localparam int unsigned CFG_BUS32_BIT  = 5;
  localparam int unsigned CFG_PKG128_BIT = 3;

  // Prom words holding the station address
  localparam logic [7:0] PROM_WORD_ADDR_LOW  = 8'h01;
  localparam logic [7:0] PROM_WORD_ADDR_MID  = 8'h02;
  localparam logic [7:0] PROM_WORD_ADDR_HIGH = 8'h03;
  // Prom word 0 carries bus width options in bits 1:0 (bit1 = 8-bit, bit0 = 16-bit)
  localparam logic [7:0] PROM_WORD_CONFIG    = 8'h00;

  // Reset values
  localparam logic [15:0] RST_WORD    = 16'h0000;
  localparam logic [3:0]  RST_PATTERN = 4'h0;

  typedef enum logic [2:0] {
    LD_IDLE,
    LD_CFG,
    LD_LOW,
    LD_MID,
    LD_HIGH,
    LD_DONE
  } load_state_t;

  // Host access carrier
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  lane_en;
    logic [15:0] wdata;
  } host_req_t;

  // Prom word read carrier
  typedef struct packed {
    logic        req;
    logic [7:0]  word;
  } prom_req_t;

  typedef struct packed {
    logic        sync1_endian;
    logic        sync2_endian;
    logic        sync1_prom;
    logic        sync2_prom;
    logic        sync1_sdi;
    logic        sync2_sdi;
    logic        straps_taken;
    load_state_t ld_state;
    logic        prom_req;
    logic [7:0]  prom_word;
    logic        lane_flag;
    logic [3:0]  lane_pattern;
    logic        cfg_endian;
    logic        cfg_prom;
    logic        cfg_bus8;
    logic        cfg_bus16;
    logic [15:0] addr_low;
    logic [15:0] addr_mid;
    logic [15:0] addr_high;
    logic [15:0] rdata;
    logic        rvalid;
    logic        load_done;
  } regs_state_t;

endpackage

// ---- tb/host_regs_asserts.sv ----
// Purpose: Port checker for the host register group
// Assumes: Bound into host_bus_config_mac_regs
// Notes:   Read data judged one cycle after the read strobe
`timescale 1ns/1ps
module host_regs_asserts
  import host_regs_pkg::*;
#(
  parameter bit BUS32_VARIANT = 1'b0,
  parameter bit LARGE_PACKAGE = 1'b1
) (
  // Clock, reset, host
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire host_req_t   host_req,
  input wire logic [15:0] host_rdata,
  input wire logic        host_rvalid,
  // Prom reader, status
  input wire logic        prom_req,
  input wire logic [7:0]  prom_word,
  input wire logic        prom_ack,
  input wire logic        load_done
);
  logic       rd_q;
  logic [6:0] a_q;
  always_ff @(posedge ref_clk) begin
    rd_q <= host_req.rd & ~rst;
    a_q  <= host_req.addr[7:1];
  end
  wire rv_cfg = host_rvalid && a_q == 7'h04;
  wire rv_err = host_rvalid && a_q == 7'h03;
  wire ack_w  = prom_req && prom_ack;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  read_answer_a: assert property (host_rvalid == rd_q)
    else $error("read answer timing wrong");
  cfg_reserved_a: assert property (rv_cfg |-> (host_rdata & 16'hF917) == 16'h0000)
    else $error("config reserved bit set");
  cfg_variant_a: assert property (rv_cfg |-> host_rdata[5] == BUS32_VARIANT
    && host_rdata[3] == LARGE_PACKAGE) else $error("config variant bits wrong");
  pattern_valid_a: assert property (rv_err && !host_rdata[15] |-> host_rdata == 16'h0000)
    else $error("pattern shown without flag");
  unmapped_zero_a: assert property (host_rvalid && !(a_q inside {7'h03, 7'h04, 7'h08,
    7'h09, 7'h0A}) |-> host_rdata == 16'h0000) else $error("unmapped read not zero");
  first_word_a: assert property ($rose(prom_req) |-> prom_word == PROM_WORD_CONFIG)
    else $error("load did not start at word 0");
  word_step_a: assert property (ack_w && prom_word != 8'h03 |=>
    prom_word == $past(prom_word) + 8'h01) else $error("prom word order wrong");
  load_end_a: assert property (ack_w && prom_word == 8'h03 |=> !prom_req ##1 load_done)
    else $error("load did not finish");
  done_hold_a: assert property (load_done |=> load_done && !prom_req)
    else $error("prom touched after load");
  cover property (rv_err && host_rdata[15]);
  cover property (ack_w && prom_word == 8'h03);
  cover property (rv_cfg);
endmodule
bind host_bus_config_mac_regs host_regs_asserts #(.BUS32_VARIANT(BUS32_VARIANT),
  .LARGE_PACKAGE(LARGE_PACKAGE)) host_regs_asserts_inst (.ref_clk, .rst, .host_req,
  .host_rdata, .host_rvalid, .prom_req, .prom_word, .prom_ack, .load_done);

// ---- tb/prom_model.sv ----
// Purpose: Prom word reader model
// Assumes: One word per request, wait of lat cycles
// Notes:   Idle data lines show the inverse of the last value
`timescale 1ns/1ps
module prom_model (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Reader port
  input  wire logic        prom_req,
  input  wire logic [7:0]  prom_word,
  output logic             prom_ack,
  output logic [15:0]      prom_data,
  // Contents and pace
  input  wire logic [1:0]  lat,
  input  wire logic [15:0] rom [4]
);
  logic [1:0] cnt;
  // Read only: there is no write path at all
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prom_ack  <= 1'b0;
      prom_data <= 16'h0000;
      cnt       <= 2'h0;
    end else if (prom_req && !prom_ack && cnt >= lat) begin
      prom_ack  <= 1'b1;
      prom_data <= rom[prom_word[1:0]];
    end else begin
      prom_ack  <= 1'b0;
      prom_data <= ~prom_data;
      cnt       <= prom_ack ? 2'h0 : cnt + 2'h1;
    end
  end
endmodule

// ---- tb/host_bus_config_mac_regs_tb.sv ----
// Purpose: Self-checking bench for the host register group
// Assumes: Default variant parameters, prom model on the reader port
// Notes:   Two passes, prom fitted then not, each after a reset
`timescale 1ns/1ps
module host_bus_config_mac_regs_tb;
  import host_regs_pkg::*;
  logic        ref_clk, rst, serial_clock_strap, prom_enable_strap, serial_data_in_strap;
  logic        host_rvalid, prom_req, prom_ack, load_done, ill;
  logic [1:0]  lat;
  logic [7:0]  prom_word, a;
  logic [15:0] host_rdata, prom_data, v;
  logic [15:0] rom [4];
  logic [15:0] expq [$];
  host_req_t   host_req;
  int          errors, num_checks;
  host_bus_config_mac_regs host_bus_config_mac_regs_inst (.ref_clk, .rst, .serial_clock_strap,
    .prom_enable_strap, .serial_data_in_strap, .host_req, .host_rdata, .host_rvalid,
    .prom_req, .prom_word, .prom_ack, .prom_data, .load_done);
  prom_model prom_model_inst (.ref_clk, .rst, .prom_req, .prom_word, .prom_ack, .prom_data,
    .lat, .rom);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Read notes d as the expected word, write sends d
  task automatic acc(input logic r, input logic [7:0] ad, input logic [3:0] l,
                     input logic [15:0] d);
    @(posedge ref_clk);
    host_req <= '{r, !r, ad, l, d};
    if (r) expq.push_back(d);
    @(posedge ref_clk);
    host_req <= '0;
  endtask
  always @(posedge ref_clk) begin
    if (host_rvalid === 1'b1) check(host_rdata, expq.size() ? expq.pop_front() : 'x);
  end
  initial begin
    repeat (6000) @(posedge ref_clk);
    errors++;
    wrap_up;
  end
  initial begin
    {rst, serial_clock_strap, prom_enable_strap, serial_data_in_strap} = 4'hF;
    {host_req, lat, errors, num_checks} = '0;
    foreach (rom[i]) rom[i] = 16'h0000;
    void'($urandom(82794));
    for (int p = 1; p >= 0; p--) begin
      @(posedge ref_clk);
      rst <= 1'b1;
      prom_enable_strap <= 1'(p);
      serial_clock_strap <= 1'($urandom);
      serial_data_in_strap <= 1'($urandom);
      lat <= 2'($urandom);
      foreach (rom[i]) rom[i] <= 16'($urandom);
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      for (int i = 0; i < 60 && load_done !== 1'b1; i++) @(posedge ref_clk);
      check({15'h0000, load_done}, 16'h0001);
      acc(1'b0, OFF_CHIP_CONFIGURATION, 4'h3, 16'hFFFF);
      v = {5'h00, serial_clock_strap, 1'(p), 1'b0, p ? rom[0][1] : serial_data_in_strap,
           p ? rom[0][0] : serial_data_in_strap, 2'h0, 1'b1, 3'h0};
      acc(1'b1, OFF_CHIP_CONFIGURATION, 4'h3, v);
      for (int k = 0; k < 3; k++) begin
        a = OFF_STATION_ADDR_LOW + 8'(2 * k);
        acc(1'b1, a, 4'hF, p ? rom[k + 1] : RST_WORD);
        v = 16'($urandom);
        acc(1'b0, a, 4'h3, v);
        acc(1'b1, a, 4'h3, v);
      end
      for (int l = 0; l < 16; l++) begin
        ill = !(l inside {1, 2, 4, 8, 3, 12, 15});
        acc(1'b1, 8'h0A, 4'(l), 16'h0000);
        acc(1'b1, 8'h0A, 4'h5, 16'h0000);
        acc(1'b0, OFF_BUS_ERROR_STATUS, 4'h3, 16'h0000);
        acc(1'b1, OFF_BUS_ERROR_STATUS, 4'h3, {1'b1, ill ? 4'(l) : 4'h5, 11'h000});
        acc(1'b0, OFF_BUS_ERROR_STATUS, 4'h3, 16'h8000);
        acc(1'b1, OFF_BUS_ERROR_STATUS, 4'h3, 16'h0000);
      end
    end
    repeat (5) @(posedge ref_clk);
    check(16'(expq.size()), 16'h0000);
    wrap_up;
  end
endmodule
